// File: slsp_map.svh
// constants for the supply-line serial port: timing, framing, command codes
// assumes a 50 MHz reference clock; included by both link ends
`ifndef SLSP_MAP_SVH
`define SLSP_MAP_SVH
// clock period and link times in ns
`define CLK_NS 20
`define T_IDLE_NS 15000000
`define T_TURN_NS 20000
`define T_ACT_NS 100000
// derived cycle counts
`define IDLE_CYC (20'(`T_IDLE_NS / `CLK_NS))
`define TURN_CYC (16'(`T_TURN_NS / `CLK_NS))
`define ACT_CYC (20'(`T_ACT_NS / `CLK_NS))
// field framing
`define SYNC_BYTE 8'h55
`define FLD_LAST 4'h9
`define SYNC_EDGES 4'h8
`define BIT_MIN 16'h0008
`define BIT_MAX 16'h0800
`define M_BIT_CYC 20'h00032
`define M_HUNT_CYC 20'h0ffff
// command field codes and data field counts
`define CMD_WR_LO 4'h1
`define CMD_RDI_LO 4'h2
`define CMD_RDR 8'h73
`define CMD_BW 8'hd0
`define CMD_BR 8'hd3
`define LEN_WR 4'h2
`define LEN_RDI 4'h1
`define LEN_RDR 4'h1
`define LEN_BW 4'h2
`define LEN_BR 4'h2
// error flag positions
`define ERR_RATE 0
`define ERR_SYNC 1
`define ERR_STOP 2
`define ERR_CMD 3
`endif

// File: slsp_pkg.sv
// types shared by both ends of the supply-line serial port
// assumes slsp_map.svh holds the numeric constants
package slsp_pkg;
  // device end states
  typedef enum logic [3:0] {
    D_OFF, D_SYNCW, D_SYNC, D_HUNT, D_RXB, D_STORE, D_TURN, D_TXB, D_DROP
  } dev_state_t;
  // master end states
  typedef enum logic [2:0] {
    M_IDLE, M_ACT, M_TXB, M_NEXT, M_HUNT, M_RXB
  } mst_state_t;
endpackage : slsp_pkg

// File: slsp_if.sv
// the supply pin seen as three logical wires between master and device
// assumes the testbench joins both ends through one instance
`timescale 1ns/10ps
interface slsp_if;
  logic vline; // supply voltage level, master to device, idle high
  logic ov;    // overvoltage activation pulse, master to device
  logic iline; // supply current level, device to master, idle high
  modport dev (input vline, input ov, output iline);
  modport mst (output vline, output ov, input iline);
endinterface : slsp_if

// File: fifo_buf.sv
// small synchronous fifo with valid/ready on both sides
// assumes one clock, synchronous active-high reset and a clock enable
`timescale 1ns/10ps
module fifo_buf #(
  parameter int W = 9,
  parameter int D = 32
) (
  // clock and control
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // fill side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  localparam int A = $clog2(D);
  logic [W-1:0] mem [D]; // storage, no reset needed
  logic [A:0] wp_r; // write pointer with wrap bit
  logic [A:0] rp_r; // read pointer with wrap bit
  wire full = (wp_r[A] != rp_r[A]) && (wp_r[A-1:0] == rp_r[A-1:0]);
  wire empty = (wp_r == rp_r);
  wire push = in_valid && !full;
  wire pop = out_ready && !empty;
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rp_r[A-1:0]];
  // storage write
  always_ff @(posedge clk)
  begin
    if (ce && push)
      mem[wp_r[A-1:0]] <= in_data;
  end
  // pointers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else if (ce)
    begin
      if (push)
        wp_r <= wp_r + 1'b1;
      if (pop)
        rp_r <= rp_r + 1'b1;
    end
  end
endmodule : fifo_buf

// File: slsp_dev.sv
// device end of the supply-line serial port: activation, sync measurement,
// field reception into a fifo, command decode, timed responses, errors
// assumes the master end drives the link; user logic answers read data
`timescale 1ns/10ps
`include "slsp_map.svh"
module slsp_dev #(
  parameter logic [19:0] IDLE_CYC = `IDLE_CYC,
  parameter logic [19:0] ACT_CYC = `ACT_CYC
) (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // link
  slsp_if.dev LINK,
  // received fields: {is_command, byte}
  output logic RX_VALID,
  input wire logic RX_READY,
  output logic [8:0] RX_WORD,
  // response bytes for read frames
  output logic RESP_REQ,
  input wire logic RESP_VALID,
  input wire logic [7:0] RESP_DATA,
  // session and status
  input wire logic LINK_OFF,
  input wire logic [3:0] ERR_CLR,
  output logic ACTIVE,
  output logic BUSY,
  output logic [3:0] ERR
);
  import slsp_pkg::*;
  dev_state_t st_r; // framing state
  logic v_r; // last line level
  logic [15:0] cnt_r; // cycles in current bit or wait
  logic [15:0] per_r; // measured bit period
  logic [15:0] prev_r; // width of previous sync bit
  logic [18:0] sum_r; // sum of sync bit widths
  logic [3:0] seg_r; // sync edges seen
  logic [3:0] bit_r; // bit index in field
  logic [3:0] rem_r; // data fields left in frame
  logic [7:0] sh_r; // receive shifter
  logic [9:0] tx_r; // transmit shifter, idles all ones
  logic [19:0] idle_r; // cycles since last line change
  logic [19:0] act_r; // overvoltage length
  logic ov_r; // last overvoltage level
  logic fcmd_r; // current field is the command
  logic txdir_r; // frame data flows to the master
  logic turned_r; // turnaround already served
  logic active_r; // receive logic enabled
  logic [3:0] err_r; // sticky error flags
  logic fifo_rdy; // fifo can take a word

  // line events
  wire fall = v_r & ~LINK.vline;
  wire chg = v_r ^ LINK.vline;
  wire idle_hit = (idle_r == IDLE_CYC);
  // sync width checks
  wire [15:0] w = cnt_r + 16'h0001;
  wire [15:0] dif = (w > prev_r) ? (w - prev_r) : (prev_r - w);
  wire sync_bad = (seg_r != 4'h0) && ({dif, 2'b00} > {2'b00, prev_r});
  wire [18:0] tot = sum_r + {3'b000, w};
  wire [15:0] per_w = tot[18:3]; // mean of eight bits
  wire sync_end = (seg_r == `SYNC_EDGES);
  wire rate_lo = chg && sync_end && (per_w < `BIT_MIN);
  wire rate_bad = (st_r == D_SYNC) && ((cnt_r >= `BIT_MAX) || rate_lo);
  wire sync_err = (st_r == D_SYNC) && chg && !rate_lo && sync_bad;
  // mid-bit sampling
  wire [15:0] per_m1 = per_r - 16'h0001;
  wire [15:0] tgt = (bit_r == 4'h0) ? {1'b0, per_r[15:1]} : per_m1;
  wire smp = (st_r == D_RXB) && (cnt_r == tgt);
  wire fld_end = smp && (bit_r == `FLD_LAST);
  wire stop_bad = fld_end && !LINK.vline;
  // command decode
  wire c_wr = !sh_r[7] && (sh_r[3:0] == `CMD_WR_LO);
  wire c_rdi = !sh_r[7] && (sh_r[3:0] == `CMD_RDI_LO);
  wire c_rdr = (sh_r == `CMD_RDR);
  wire c_bw = (sh_r == `CMD_BW);
  wire c_br = (sh_r == `CMD_BR);
  wire c_ok = c_wr | c_rdi | c_rdr | c_bw | c_br;
  wire c_tx = c_rdr | c_br;
  wire [3:0] c_len = c_wr ? `LEN_WR : c_rdi ? `LEN_RDI :
                     c_rdr ? `LEN_RDR : c_bw ? `LEN_BW : `LEN_BR;
  wire cmd_err = fld_end && LINK.vline && fcmd_r && !c_ok;
  wire turn_done = turned_r || (cnt_r >= `TURN_CYC);
  wire tx_tick = (st_r == D_TXB) && (cnt_r == per_m1);
  wire [3:0] err_set;
  assign err_set[`ERR_RATE] = rate_bad;
  assign err_set[`ERR_SYNC] = sync_err;
  assign err_set[`ERR_STOP] = stop_bad;
  assign err_set[`ERR_CMD] = cmd_err;

  // outputs
  assign LINK.iline = tx_r[0];
  assign RESP_REQ = (st_r == D_TURN) && turn_done;
  assign ACTIVE = active_r;
  assign BUSY = (st_r != D_OFF) && (st_r != D_SYNCW);
  assign ERR = err_r;

  // every received command and data field waits here until the fifo has room
  fifo_buf #(.W(9), .D(32)) u_rxq (
    .clk(REF_CLK),
    .rst(RST),
    .ce(CE),
    .in_valid(st_r == D_STORE),
    .in_data({fcmd_r, sh_r}),
    .in_ready(fifo_rdy),
    .out_valid(RX_VALID),
    .out_data(RX_WORD),
    .out_ready(RX_READY)
  );

  // line history and idle timer
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      v_r <= 1'b1;
      idle_r <= '0;
    end
    else if (CE)
    begin
      v_r <= LINK.vline;
      if (chg)
        idle_r <= '0;
      else if (!idle_hit)
        idle_r <= idle_r + 20'h00001;
    end
  end

  // activation pulse; the processor side ends the session via LINK_OFF
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      ov_r <= 1'b0;
      act_r <= '0;
      active_r <= 1'b0;
    end
    else if (CE)
    begin
      ov_r <= LINK.ov;
      if (!LINK.ov)
        act_r <= '0;
      else if (act_r != ACT_CYC)
        act_r <= act_r + 20'h00001;
      if (LINK_OFF)
        active_r <= 1'b0;
      else if (ov_r && !LINK.ov && (act_r == ACT_CYC))
        active_r <= 1'b1;
    end
  end

  // sticky errors, a new error wins over a clear in the same cycle
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
      err_r <= '0;
    else if (CE)
      err_r <= (err_r & ~ERR_CLR) | err_set;
  end

  // framing state machine
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st_r <= D_OFF;
      cnt_r <= '0;
      per_r <= `BIT_MIN;
      prev_r <= '0;
      sum_r <= '0;
      seg_r <= '0;
      bit_r <= '0;
      rem_r <= '0;
      sh_r <= '0;
      tx_r <= '1;
      fcmd_r <= 1'b0;
      txdir_r <= 1'b0;
      turned_r <= 1'b0;
    end
    else if (CE)
    begin
      if (!active_r)
        st_r <= D_OFF;
      else if (idle_hit && !fall && st_r != D_TURN && st_r != D_TXB)
        st_r <= D_SYNCW;
      else
        unique case (st_r)
          D_OFF:
            st_r <= D_SYNCW;
          // first edge of a frame is taken as the sync start bit
          D_SYNCW:
            if (fall)
            begin
              st_r <= D_SYNC;
              cnt_r <= '0;
              seg_r <= '0;
              sum_r <= '0;
            end
          D_SYNC:
            if (rate_bad || sync_err)
              st_r <= D_DROP;
            else if (chg)
            begin
              cnt_r <= '0;
              prev_r <= w;
              seg_r <= seg_r + 4'h1;
              if (seg_r != 4'h0)
                sum_r <= tot;
              if (sync_end)
              begin
                per_r <= per_w;
                fcmd_r <= 1'b1;
                st_r <= D_HUNT;
              end
            end
            else
              cnt_r <= cnt_r + 16'h0001;
          // a gap before a start bit is fine until the idle timeout
          D_HUNT:
            if (fall)
            begin
              st_r <= D_RXB;
              cnt_r <= '0;
              bit_r <= '0;
            end
          D_RXB:
            if (!smp)
              cnt_r <= cnt_r + 16'h0001;
            else
            begin
              cnt_r <= '0;
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h0 && LINK.vline)
                st_r <= D_HUNT; // glitch, not a start bit
              else if (bit_r != `FLD_LAST)
              begin
                if (bit_r != 4'h0)
                  sh_r <= {LINK.vline, sh_r[7:1]};
              end
              else if (stop_bad || cmd_err)
                st_r <= D_DROP;
              else
              begin
                st_r <= D_STORE;
                if (fcmd_r)
                begin
                  rem_r <= c_len;
                  txdir_r <= c_tx;
                  turned_r <= 1'b0;
                end
                else
                  rem_r <= rem_r - 4'h1;
              end
            end
          D_STORE:
            if (fifo_rdy)
            begin
              fcmd_r <= 1'b0;
              cnt_r <= '0;
              if (rem_r == 4'h0)
                st_r <= D_SYNCW;
              else if (txdir_r)
                st_r <= D_TURN;
              else
                st_r <= D_HUNT;
            end
          // wait out the turnaround, then the byte from user logic
          D_TURN:
            if (turn_done && RESP_VALID)
            begin
              tx_r <= {1'b1, RESP_DATA, 1'b0};
              turned_r <= 1'b1;
              cnt_r <= '0;
              bit_r <= '0;
              st_r <= D_TXB;
            end
            else if (!turn_done)
              cnt_r <= cnt_r + 16'h0001;
          D_TXB:
            if (!tx_tick)
              cnt_r <= cnt_r + 16'h0001;
            else
            begin
              cnt_r <= '0;
              tx_r <= {1'b1, tx_r[9:1]};
              bit_r <= bit_r + 4'h1;
              if (bit_r == `FLD_LAST)
              begin
                rem_r <= rem_r - 4'h1;
                st_r <= (rem_r == 4'h1) ? D_SYNCW : D_TURN;
              end
            end
          // rest of a bad frame is ignored until the line idles
          D_DROP:
            st_r <= D_DROP;
        endcase
    end
  end
endmodule : slsp_dev

// File: slsp_mst.sv
// master end of the supply-line serial port: activation pulse, frames of
// sync, command and data fields, reception of device answers
// assumes the device end shares the link and measures the sync field
`timescale 1ns/10ps
`include "slsp_map.svh"
module slsp_mst #(
  parameter logic [19:0] ACT_CYC = `ACT_CYC
) (
  // clock, reset, enable
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic CE,
  // link
  slsp_if.mst LINK,
  // session and frame requests
  input wire logic ACT_REQ,
  input wire logic FRM_VALID,
  output logic FRM_READY,
  input wire logic [7:0] FRM_CMD,
  input wire logic [3:0] FRM_LEN,
  input wire logic FRM_RD,
  // bytes to send
  input wire logic DAT_VALID,
  output logic DAT_READY,
  input wire logic [7:0] DAT_BYTE,
  // bytes received
  output logic RX_VALID,
  output logic [7:0] RX_BYTE,
  output logic BUSY
);
  import slsp_pkg::*;
  mst_state_t st_r; // sequencing state
  logic [19:0] cnt_r; // bit or wait counter
  logic [3:0] bit_r; // bit index in field
  logic [9:0] tx_r; // transmit shifter, idles all ones
  logic [7:0] sh_r; // receive shifter
  logic [7:0] cmd_r; // held command field
  logic [3:0] rem_r; // data fields left
  logic rd_r; // data flows from device
  logic sync_r; // sync just sent, command next
  logic ov_r; // activation drive
  logic i_r; // last current level
  logic rxv_r; // received byte pulse
  logic [7:0] rxb_r; // received byte

  wire bit_end = (cnt_r == `M_BIT_CYC - 20'h00001);
  wire mid = (cnt_r == (`M_BIT_CYC >> 1));
  wire smp = (st_r == M_RXB) && ((bit_r == 4'h0) ? mid : bit_end);
  wire ifall = i_r & ~LINK.iline;
  wire need_dat = (st_r == M_NEXT) && !sync_r && !rd_r && (rem_r != 4'h0);

  assign FRM_READY = (st_r == M_IDLE) && !ACT_REQ;
  assign DAT_READY = need_dat;
  assign LINK.vline = tx_r[0];
  assign LINK.ov = ov_r;
  assign RX_VALID = rxv_r;
  assign RX_BYTE = rxb_r;
  assign BUSY = (st_r != M_IDLE);

  // sequencing: the master alone opens and closes each frame
  always_ff @(posedge REF_CLK)
  begin
    if (RST)
    begin
      st_r <= M_IDLE;
      cnt_r <= '0;
      bit_r <= '0;
      tx_r <= '1;
      sh_r <= '0;
      cmd_r <= '0;
      rem_r <= '0;
      rd_r <= 1'b0;
      sync_r <= 1'b0;
      ov_r <= 1'b0;
      i_r <= 1'b1;
      rxv_r <= 1'b0;
      rxb_r <= '0;
    end
    else if (CE)
    begin
      i_r <= LINK.iline;
      rxv_r <= 1'b0;
      unique case (st_r)
        M_IDLE:
          if (ACT_REQ)
          begin
            st_r <= M_ACT;
            ov_r <= 1'b1;
            cnt_r <= '0;
          end
          else if (FRM_VALID)
          begin
            tx_r <= {1'b1, `SYNC_BYTE, 1'b0};
            cmd_r <= FRM_CMD;
            rem_r <= FRM_LEN;
            rd_r <= FRM_RD;
            sync_r <= 1'b1;
            cnt_r <= '0;
            bit_r <= '0;
            st_r <= M_TXB;
          end
        M_ACT:
          if (cnt_r == ACT_CYC)
          begin
            ov_r <= 1'b0;
            st_r <= M_IDLE;
          end
          else
            cnt_r <= cnt_r + 20'h00001;
        M_TXB:
          if (!bit_end)
            cnt_r <= cnt_r + 20'h00001;
          else
          begin
            cnt_r <= '0;
            tx_r <= {1'b1, tx_r[9:1]};
            bit_r <= bit_r + 4'h1;
            if (bit_r == `FLD_LAST)
              st_r <= M_NEXT;
          end
        // pick the next field; a wait here is a legal gap
        M_NEXT:
          begin
            cnt_r <= '0;
            bit_r <= '0;
            if (sync_r)
            begin
              tx_r <= {1'b1, cmd_r, 1'b0};
              sync_r <= 1'b0;
              st_r <= M_TXB;
            end
            else if (rem_r == 4'h0)
              st_r <= M_IDLE;
            else if (rd_r)
              st_r <= M_HUNT;
            else if (DAT_VALID)
            begin
              tx_r <= {1'b1, DAT_BYTE, 1'b0};
              rem_r <= rem_r - 4'h1;
              st_r <= M_TXB;
            end
          end
        // a silent device must not hang the master
        M_HUNT:
          if (ifall)
          begin
            cnt_r <= '0;
            bit_r <= '0;
            st_r <= M_RXB;
          end
          else if (cnt_r == `M_HUNT_CYC)
            st_r <= M_IDLE;
          else
            cnt_r <= cnt_r + 20'h00001;
        M_RXB:
          if (!smp)
            cnt_r <= cnt_r + 20'h00001;
          else
          begin
            cnt_r <= '0;
            bit_r <= bit_r + 4'h1;
            if (bit_r != `FLD_LAST)
            begin
              if (bit_r != 4'h0)
                sh_r <= {LINK.iline, sh_r[7:1]};
            end
            else
            begin
              rxv_r <= 1'b1;
              rxb_r <= sh_r;
              rem_r <= rem_r - 4'h1;
              st_r <= M_NEXT;
            end
          end
      endcase
    end
  end
endmodule : slsp_mst

// File: slsp_checker.sv
// timing checks on the supply-line link between the master and device ends
// assumes the testbench wires these inputs to the interface joining them
`timescale 1ns/10ps
module slsp_checker #(
  parameter logic [19:0] ACT_CYC = 20'h01388
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RST,
  // link wires
  input wire logic vline,
  input wire logic ov,
  input wire logic iline,
  // device status and response handshake
  input wire logic ACTIVE,
  input wire logic RESP_REQ,
  input wire logic RESP_VALID
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  logic [15:0] hi_cnt_r; // cycles with both wires high, saturating
  logic [19:0] ov_cnt_r; // length of the running overvoltage pulse
  logic [19:0] ov_len_r; // length of the last finished pulse
  logic resp_seen_r; // a byte already went out in this frame
  // quiet-line timer, cleared by any low level on either wire
  always_ff @(posedge REF_CLK)
    if (RST || !vline || !iline) hi_cnt_r <= 16'h0000;
    else if (hi_cnt_r != 16'hffff) hi_cnt_r <= hi_cnt_r + 16'h0001;
  // pulse length counter
  always_ff @(posedge REF_CLK)
    if (RST || !ov) ov_cnt_r <= 20'h00000;
    else ov_cnt_r <= ov_cnt_r + 20'h00001;
  // latch length at the falling edge of the pulse
  always_ff @(posedge REF_CLK)
    if (RST) ov_len_r <= 20'h00000;
    else if (!ov && ov_cnt_r != 20'h00000) ov_len_r <= ov_cnt_r;
  // second burst byte has no turnaround, so track the first one
  always_ff @(posedge REF_CLK)
    if (RST || !vline) resp_seen_r <= 1'b0;
    else if (RESP_REQ && RESP_VALID) resp_seen_r <= 1'b1;

  a_reset_silent: assert property (disable iff (1'b0) RST |=> iline)
    else $error("device current line low after reset");
  a_silent_inactive: assert property (!ACTIVE |-> iline)
    else $error("device drives link while inactive");
  a_master_yields: assert property (!iline |-> vline && !ov)
    else $error("master not idle while device drives");
  a_start_width: assert property ($fell(iline) |-> !iline [*8])
    else $error("device start bit too short");
  a_turnaround_wait: assert property ($rose(RESP_REQ) && !resp_seen_r
    |-> hi_cnt_r >= 16'h03e8)
    else $error("response requested before turnaround");
  a_resp_drive: assert property (RESP_REQ && RESP_VALID
    |-> ##[1:100] !iline)
    else $error("response byte not sent");
  a_no_req_off: assert property (!ACTIVE |-> !RESP_REQ)
    else $error("response request while inactive");
  a_act_length: assert property ($rose(ACTIVE) |-> ov_len_r >= ACT_CYC)
    else $error("activation after too short a pulse");

  c_activated: cover property ($rose(ACTIVE));
  c_resp_req: cover property ($rose(RESP_REQ));
  c_dev_start: cover property ($fell(iline));
endmodule : slsp_checker

// File: supply_line_serial_slave_test.sv
// testbench: master and device ends joined, plus a second device end
// driven directly by the bench to break the link rules on purpose
`timescale 1ns/10ps
module supply_line_serial_slave_test;
  logic clk, rst = 1'b1, act_req = 1'b0, frm_valid = 1'b0, frm_rd = 1'b0;
  logic dat_valid = 1'b0, rx_ready = 1'b0, rx_ready2 = 1'b0;
  // short activation and framing timeout keep the run brief
  localparam logic [19:0] act_len = 20'h00014;
  localparam logic [19:0] idle_len = 20'h007d0;
  logic resp_valid = 1'b1, link_off = 1'b0;
  logic ce = 1'b1, resp_valid2 = 1'b0, busy2;
  logic [7:0] resp_data2 = 8'h00; // second end never answers
  logic [7:0] frm_cmd = 8'h00, dat_byte = 8'h00, resp_data = 8'h3c;
  logic [3:0] frm_len = 4'h0, err_clr = 4'h0;
  logic frm_ready, dat_ready, m_rx_valid, m_busy, d_rx_valid, resp_req;
  logic active, d_rx_valid2, active2;
  logic [7:0] m_rx_byte;
  logic [8:0] d_rx_word, d_rx_word2;
  logic [3:0] err, err2;
  int err_count = 0, checked = 0, n, k, i;
  logic [7:0] mrx_q[$]; // bytes the master received
  logic [7:0] cmds[3] = '{8'h21, 8'h52, 8'hd0};
  logic [3:0] lens[3] = '{4'h2, 4'h1, 4'h2};
  int bad[4][5] = '{'{50, 70, 2, 1, 2}, '{5, 5, 2, 1, 1},
                    '{55, 55, 2, 0, 4}, '{55, 55, 68, 1, 8}};
  slsp_if lk();
  slsp_if lk2();
  slsp_mst #(.ACT_CYC(act_len)) i_slsp_mst (.REF_CLK(clk), .RST(rst),
    .CE(ce), .LINK(lk.mst), .ACT_REQ(act_req), .FRM_VALID(frm_valid),
    .FRM_READY(frm_ready), .FRM_CMD(frm_cmd), .FRM_LEN(frm_len),
    .FRM_RD(frm_rd), .DAT_VALID(dat_valid), .DAT_READY(dat_ready),
    .DAT_BYTE(dat_byte), .RX_VALID(m_rx_valid), .RX_BYTE(m_rx_byte),
    .BUSY(m_busy));
  slsp_dev #(.IDLE_CYC(idle_len), .ACT_CYC(act_len)) i_slsp_dev (
    .REF_CLK(clk), .RST(rst), .CE(ce), .LINK(lk.dev),
    .RX_VALID(d_rx_valid), .RX_READY(rx_ready), .RX_WORD(d_rx_word),
    .RESP_REQ(resp_req), .RESP_VALID(resp_valid), .RESP_DATA(resp_data),
    .LINK_OFF(link_off), .ERR_CLR(err_clr), .ACTIVE(active), .BUSY(),
    .ERR(err));
  slsp_dev #(.IDLE_CYC(idle_len), .ACT_CYC(act_len)) i_slsp_dev_b (
    .REF_CLK(clk), .RST(rst), .CE(ce), .LINK(lk2.dev),
    .RX_VALID(d_rx_valid2), .RX_READY(rx_ready2), .RX_WORD(d_rx_word2),
    .RESP_REQ(), .RESP_VALID(resp_valid2), .RESP_DATA(resp_data2),
    .LINK_OFF(link_off), .ERR_CLR(err_clr), .ACTIVE(active2), .BUSY(busy2),
    .ERR(err2));
  slsp_checker #(.ACT_CYC(act_len)) i_slsp_checker (.REF_CLK(clk),
    .RST(rst), .vline(lk.vline), .ov(lk.ov), .iline(lk.iline),
    .ACTIVE(active), .RESP_REQ(resp_req), .RESP_VALID(resp_valid));

  // 50 MHz reference clock
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // collect master receive pulses
  always @(posedge clk)
    if (m_rx_valid === 1'b1) mrx_q.push_back(m_rx_byte);
  // answer each response request with the next byte of a ramp
  always @(posedge clk)
    if (resp_req === 1'b1 && resp_valid) resp_data <= resp_data + 8'h11;
  // hang guard, sized above the expected run length
  initial
  begin
    repeat (90000) @(posedge clk);
    err_count++;
    final_report();
  end

  task step;
    @(posedge clk);
    #1;
  endtask : step
  task chk(input logic [8:0] seen, input logic [8:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // one frame through the master end, then wait for it to go idle
  task send_frame(input logic [7:0] c, input logic [3:0] len,
                  input logic rd, input logic [7:0] b0, input logic [7:0] b1);
    frm_cmd = c;
    frm_len = len;
    frm_rd = rd;
    frm_valid = 1'b1;
    for (n = 0; n < 100 && frm_ready !== 1'b1; n++) step();
    step();
    frm_valid = 1'b0;
    for (k = 0; k < len && !rd; k++)
    begin
      dat_byte = k[0] ? b1 : b0;
      dat_valid = 1'b1;
      for (n = 0; n < 3000 && dat_ready !== 1'b1; n++) step();
      step();
    end
    dat_valid = 1'b0;
    for (n = 0; n < 8000 && m_busy !== 1'b0; n++) step();
    repeat (60) step();
  endtask : send_frame
  // pop one device word and compare it
  task pop_chk(input logic [8:0] exp);
    for (n = 0; n < 3000 && d_rx_valid !== 1'b1; n++) step();
    chk(d_rx_word, exp);
    rx_ready = 1'b1;
    step();
    rx_ready = 1'b0;
    step();
  endtask : pop_chk
  task pop2(input logic [8:0] exp);
    chk(d_rx_word2, exp);
    rx_ready2 = 1'b1;
    step();
    rx_ready2 = 1'b0;
    step();
  endtask : pop2
  // raw bit and field on the second link; segment widths alternate
  task bit2(input logic v, input int w);
    lk2.vline = v;
    repeat (w) step();
  endtask : bit2
  task fld2(input logic [7:0] b, input int w0, input int w1, input logic s);
    bit2(1'b0, w0);
    for (k = 0; k < 8; k++) bit2(b[k], k[0] ? w0 : w1);
    bit2(s, w0);
    bit2(1'b1, 30);
  endtask : fld2
  // sync, command, one data field, then idle past the framing timeout
  task frame2(input int w0, input int w1, input logic [7:0] c, input logic s);
    fld2(8'h55, w0, w1, 1'b1);
    fld2(c, 55, 55, s);
    fld2(8'ha5, 55, 55, 1'b1);
    repeat (2100) step();
  endtask : frame2
  task final_report;
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : final_report

  initial
  begin
    lk2.vline = 1'b1;
    lk2.ov = 1'b0;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    step();
    chk(9'(lk.iline), 9'h001);
    chk({active, err, d_rx_valid}, 9'h000);
    // second end: frame before activation is ignored
    frame2(55, 55, 8'h02, 1'b1);
    chk(9'(d_rx_valid2), 9'h000);
    lk2.ov = 1'b1;
    repeat (10) step();
    lk2.ov = 1'b0;
    repeat (5) step();
    chk(9'(active2), 9'h000);
    lk2.ov = 1'b1;
    repeat (30) step();
    lk2.ov = 1'b0;
    repeat (5) step();
    chk(9'(active2), 9'h001);
    // sync widths 20 percent apart still accepted, gaps between fields
    frame2(50, 60, 8'h02, 1'b1);
    pop2(9'h102);
    pop2(9'h0a5);
    // broken sync then idle: framing restarts at the next sync
    bit2(1'b0, 50);
    chk(9'(busy2), 9'h001);
    bit2(1'b1, 2150);
    chk(9'(busy2), 9'h000);
    frame2(55, 55, 8'h02, 1'b1);
    pop2(9'h102);
    pop2(9'h0a5);
    // error table: sync mismatch, rate, stop bit, unknown command
    for (i = 0; i < 4; i++)
    begin
      frame2(bad[i][0], bad[i][1], 8'(bad[i][2]), bad[i][3][0]);
      chk(9'(err2), 9'(bad[i][4]));
      chk(9'(d_rx_valid2), 9'h000);
      err_clr = 4'hf;
      step();
      err_clr = 4'h0;
      step();
      chk(9'(err2), 9'h000);
    end
    // main link: activation by the master end
    act_req = 1'b1;
    step();
    act_req = 1'b0;
    for (n = 0; n < 300 && active !== 1'b1; n++) step();
    chk(9'(active), 9'h001);
    // write, read-init and burst write commands
    for (i = 0; i < 3; i++)
    begin
      send_frame(cmds[i], lens[i], 1'b0, 8'h10 + 8'(i), 8'hf0 - 8'(i));
      pop_chk({1'b1, cmds[i]});
      pop_chk({1'b0, 8'h10 + 8'(i)});
      if (lens[i] == 4'h2) pop_chk({1'b0, 8'hf0 - 8'(i)});
    end
    // read response and burst read, device answers after turnaround
    send_frame(8'h73, 4'h1, 1'b1, 8'h00, 8'h00);
    pop_chk(9'h173);
    chk(9'(mrx_q.pop_front()), 9'h03c);
    send_frame(8'hd3, 4'h2, 1'b1, 8'h00, 8'h00);
    pop_chk(9'h1d3);
    chk(9'(mrx_q.pop_front()), 9'h04d);
    chk(9'(mrx_q.pop_front()), 9'h05e);
    chk({5'h00, err}, 9'h000);
    // fill the 32-word buffer with no reader, then drain it
    for (i = 0; i < 10; i++) send_frame(8'h01, 4'h2, 1'b0, 8'(i), ~8'(i));
    send_frame(8'h01, 4'h1, 1'b0, 8'h77, 8'h00);
    repeat (2100) step();
    for (i = 0; i < 10; i++)
    begin
      pop_chk(9'h101);
      pop_chk({1'b0, 8'(i)});
      pop_chk({1'b0, ~8'(i)});
    end
    pop_chk(9'h101);
    pop_chk(9'h077);
    chk(9'(d_rx_valid), 9'h000);
    // a frozen clock enable holds state, so the session end waits
    ce = 1'b0;
    link_off = 1'b1;
    step();
    chk(9'(active), 9'h001);
    ce = 1'b1;
    step();
    link_off = 1'b0;
    step();
    chk(9'(active), 9'h000);
    final_report();
  end
endmodule : supply_line_serial_slave_test
